// >>> bench/asp_audio_peer.sv
module asp_audio_peer (
	input wire logic clk,
	output logic [31:0] s_axis_tdata,
	output logic s_axis_tvalid,
	input wire logic s_axis_tready,
	input wire logic [31:0] m_axis_tdata,
	input wire logic m_axis_tvalid
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] sent_q[$];
	logic [31:0] got_q[$];
	int lost = 0;
	initial begin
		s_axis_tdata = 32'h0000_0000;
		s_axis_tvalid = 1'b0;
	end
	// word and valid stay put until an edge samples ready high or 4000 edges pass
	task automatic send(input logic [31:0] w);
		int n;
		s_axis_tdata <= w;
		s_axis_tvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (s_axis_tready !== 1'b1 && n < 4000);
		if (n < 4000)
			sent_q.push_back(w);
		else
			lost++;
	endtask : send
	// released data toggles so a stale word never looks valid
	task automatic release_bus();
		s_axis_tvalid <= 1'b0;
		s_axis_tdata <= ~s_axis_tdata;
	endtask : release_bus
	// takes every offered word in its own cycle, no back-pressure
	always @(posedge clk) begin
		if (m_axis_tvalid === 1'b1)
			got_q.push_back(m_axis_tdata);
	end
endmodule : asp_audio_peer

// >>> bench/asp_packetizer_bench.sv
module asp_packetizer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk;
	logic sys_rst;
	logic tx_enable;
	logic [3:0] cfg_chan_count;
	logic [31:0] s_axis_tdata;
	logic s_axis_tvalid;
	logic s_axis_tready;
	logic [7:0] tx_pkt_data;
	logic tx_pkt_valid;
	logic tx_pkt_sop;
	logic tx_pkt_eop;
	logic [7:0] rx_pkt_data = 8'h00;
	logic rx_pkt_valid = 1'b0;
	logic rx_pkt_sop = 1'b0;
	logic [31:0] m_axis_tdata;
	logic m_axis_tvalid;
	logic rx_flag_clear;
	logic rx_overflow;
	logic rx_parity_err;
	logic rx_pkt_dropped;
	logic cfg_unsupported;
	int error_cnt = 0;
	int check_count = 0;
	int pkt_cnt = 0;
	int stall_cnt = 0;
	int cut_pos = 99;
	int pos = 0;
	logic in_pkt = 1'b0;
	logic bad_pkt = 1'b0;
	logic [31:0] w = 32'h0;
	logic [7:0] hdr_exp;
	logic [31:0] rx_exp[$];

	asp_packetizer #(.FIFO_DEPTH(16)) DUT (.clk, .sys_rst, .tx_enable, .cfg_chan_count,
		.s_axis_tdata, .s_axis_tvalid, .s_axis_tready, .tx_pkt_data, .tx_pkt_valid,
		.tx_pkt_sop, .tx_pkt_eop, .rx_pkt_data, .rx_pkt_valid, .rx_pkt_sop, .m_axis_tdata,
		.m_axis_tvalid, .rx_flag_clear, .rx_overflow, .rx_parity_err, .rx_pkt_dropped,
		.cfg_unsupported);
	asp_audio_peer PEER (.clk, .s_axis_tdata, .s_axis_tvalid, .s_axis_tready,
		.m_axis_tdata, .m_axis_tvalid);

	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk_word

	// link monitor and loopback; cut_pos flips bit 0 of one byte on the way back
	always @(posedge clk) begin
		if (s_axis_tvalid === 1'b1 && s_axis_tready !== 1'b1)
			stall_cnt++;
		rx_pkt_valid <= tx_pkt_valid;
		rx_pkt_sop <= tx_pkt_sop;
		if (tx_pkt_valid === 1'b1) begin
			pos = (tx_pkt_sop === 1'b1) ? 0 : pos + 1;
			if (pos == 0) begin
				pkt_cnt++;
				bad_pkt = (cut_pos < 8);
			end
			in_pkt = (pos < 47);
			chk_bit(tx_pkt_sop, pos == 0);
			chk_bit(tx_pkt_eop, pos == 47);
			hdr_exp = (pos == 3) ? {4'h0, cfg_chan_count - 4'h1} : (pos == 2) ? asp_pkg::HB2_RSVD
				: (pos == 1) ? asp_pkg::HB1_TYPE_AUDIO : asp_pkg::HB0_ID;
			if (pos < 4)
				chk_byte(tx_pkt_data, hdr_exp);
			if (pos >= 8 && (pos - 8) % 5 == 0 && PEER.sent_q.size() > 0)
				w = PEER.sent_q.pop_front();
			if (pos >= 8 && (pos - 8) % 5 < 4)
				chk_byte(tx_pkt_data, w[8*((pos-8)%5) +: 8]);
			if (pos >= 8 && (pos - 8) % 5 == 4 && !bad_pkt && (cut_pos < pos - 4 || cut_pos > pos))
				rx_exp.push_back(w);
			rx_pkt_data <= (pos == cut_pos) ? tx_pkt_data ^ 8'h01 : tx_pkt_data;
		end else begin
			chk_bit(in_pkt, 1'b0);
			rx_pkt_data <= ~rx_pkt_data;
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic send_n(input int n, input logic [31:0] base);
		for (int i = 0; i < n; i++)
			PEER.send(base + 32'(i) * 32'h0013_5791);
		PEER.release_bus();
		chk_word(32'(PEER.lost), 32'h0);
	endtask : send_n
	task automatic drain_check();
		chk_word(32'(PEER.got_q.size()), 32'(rx_exp.size()));
		while (PEER.got_q.size() > 0 && rx_exp.size() > 0)
			chk_word(PEER.got_q.pop_front(), rx_exp.pop_front());
		PEER.got_q.delete();
		rx_exp.delete();
	endtask : drain_check

	task automatic t_reset();
		sys_rst <= 1'b1;
		cyc(3);
		chk_bit(s_axis_tready | tx_pkt_valid | m_axis_tvalid, 1'b0);
		chk_bit(rx_parity_err | rx_pkt_dropped | rx_overflow, 1'b0);
		sys_rst <= 1'b0;
		cyc(3);
		chk_bit(s_axis_tready, 1'b1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_packet(input logic [3:0] chan);
		int base;
		cfg_chan_count <= chan;
		cyc(3);
		base = pkt_cnt;
		send_n(7, 32'hA000_0003 + 32'(chan));
		cyc(20);
		chk_word(32'(pkt_cnt), 32'(base));
		send_n(1, 32'h5F00_00C0);
		cyc(70);
		chk_word(32'(pkt_cnt), 32'(base + 1));
		drain_check();
		$display("test packet done");
	endtask : t_packet
	task automatic t_unsupp();
		int codes[4] = '{0, 3, 8, 15};
		foreach (codes[i]) begin
			cfg_chan_count <= 4'(codes[i]);
			cyc(3);
			chk_bit(cfg_unsupported, 1'b1);
			chk_bit(s_axis_tready, 1'b0);
		end
		cfg_chan_count <= 4'h2;
		cyc(3);
		chk_bit(cfg_unsupported, 1'b0);
		$display("test unsupported done");
	endtask : t_unsupp
	task automatic t_enable();
		tx_enable <= 1'b0;
		cyc(3);
		fork
			send_n(8, 32'h3C00_0A05);
			begin
				cyc(10);
				chk_word(32'(PEER.sent_q.size()), 32'h0);
				chk_bit(s_axis_tready, 1'b0);
				tx_enable <= 1'b1;
			end
		join
		cyc(70);
		drain_check();
		$display("test enable done");
	endtask : t_enable
	task automatic t_fill();
		stall_cnt = 0;
		send_n(24, 32'h7100_0001);
		cyc(150);
		chk_bit(stall_cnt > 0, 1'b1);
		drain_check();
		$display("test fill done");
	endtask : t_fill
	task automatic t_parity();
		cut_pos = 9;
		send_n(8, 32'h9E00_1234);
		cyc(70);
		chk_bit(rx_parity_err, 1'b1);
		drain_check();
		cut_pos = 1;
		send_n(8, 32'h2B00_0F0F);
		cyc(70);
		chk_bit(rx_pkt_dropped, 1'b1);
		drain_check();
		cut_pos = 99;
		rx_flag_clear <= 1'b1;
		cyc(1);
		rx_flag_clear <= 1'b0;
		cyc(2);
		chk_bit(rx_parity_err | rx_pkt_dropped, 1'b0);
		$display("test parity done");
	endtask : t_parity

	task automatic summarize();
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("watchdog expired");
		summarize();
	end
	initial begin
		sys_rst = 1'b1;
		tx_enable = 1'b1;
		cfg_chan_count = 4'h2;
		rx_flag_clear = 1'b0;
		@(posedge clk);
		t_reset();
		t_packet(4'h2);
		t_packet(4'h1);
		t_unsupp();
		t_enable();
		t_fill();
		t_parity();
		summarize();
	end
endmodule : asp_packetizer_bench

// >>> verilog/asp_fifo.sv
module asp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	localparam int AW = $clog2(DEPTH)
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [AW:0] count
);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = count_r != (AW+1)'(DEPTH);
	assign out_valid = count_r != '0;
	assign out_data = mem_r[rd_ptr_r];
	assign count = count_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + AW'(push);
			rd_ptr_r <= rd_ptr_r + AW'(pop);
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : asp_fifo

// >>> verilog/asp_packetizer.sv
module asp_packetizer #(
	parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH,
	localparam int CW = $clog2(FIFO_DEPTH) + 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tx_enable,
	input wire logic [3:0] cfg_chan_count,
	input wire logic [31:0] s_axis_tdata,
	input wire logic s_axis_tvalid,
	output logic s_axis_tready,
	output logic [7:0] tx_pkt_data,
	output logic tx_pkt_valid,
	output logic tx_pkt_sop,
	output logic tx_pkt_eop,
	input wire logic [7:0] rx_pkt_data,
	input wire logic rx_pkt_valid,
	input wire logic rx_pkt_sop,
	output logic [31:0] m_axis_tdata,
	output logic m_axis_tvalid,
	input wire logic rx_flag_clear,
	output logic rx_overflow,
	output logic rx_parity_err,
	output logic rx_pkt_dropped,
	output logic cfg_unsupported
);
	if (FIFO_DEPTH < asp_pkg::SMP_PER_PKT) begin : g_chk
		$error("fifo must hold one packet of samples");
	end

	logic chan_ok;
	logic accept_ok;
	logic tready_r;
	logic push;
	logic txf_in_ready;
	logic txf_out_valid;
	logic txf_out_ready;
	logic [31:0] txf_out_data;
	logic [CW-1:0] txf_count;
	asp_pkg::asp_state_t tx_st_r;
	logic [2:0] cnt_r;
	logic [2:0] smp_r;
	logic [3:0] hdr_cc_r;
	logic [7:0] tx_byte;
	logic [31:0] tx_par_word;
	logic [7:0] tx_par;
	logic [7:0] tx_data_r;
	logic tx_valid_r;
	logic tx_sop_r;
	logic tx_eop_r;
	logic unsup_r;

	// plain settings stand in for the packed configuration word
	assign chan_ok = cfg_chan_count >= asp_pkg::MIN_CHAN
		&& cfg_chan_count <= asp_pkg::MAX_CHAN;
	assign accept_ok = tx_enable && chan_ok;
	assign push = s_axis_tvalid && tready_r;
	assign s_axis_tready = tready_r;
	assign txf_out_ready = tx_st_r == asp_pkg::st_pay && cnt_r == asp_pkg::PAR_IDX;

	// ready is registered, so it drops while one slot still remains
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tready_r <= asp_pkg::RST_FLAG;
			unsup_r <= asp_pkg::RST_FLAG;
		end else begin
			tready_r <= accept_ok && txf_count <= CW'(FIFO_DEPTH - 2);
			unsup_r <= !chan_ok;
		end
	end

	asp_fifo #(
		.WIDTH(asp_pkg::DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_txf (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(push),
		.in_ready(txf_in_ready),
		.in_data(s_axis_tdata),
		.out_valid(txf_out_valid),
		.out_ready(txf_out_ready),
		.out_data(txf_out_data),
		.count(txf_count)
	);

	function automatic logic [7:0] hdr_byte(input logic [1:0] k, input logic [3:0] cc);
		case (k)
			2'h0: hdr_byte = asp_pkg::HB0_ID;
			2'h1: hdr_byte = asp_pkg::HB1_TYPE_AUDIO;
			2'h2: hdr_byte = asp_pkg::HB2_RSVD;
			default: hdr_byte = {4'h0, cc};
		endcase
	endfunction : hdr_byte

	// header parity covers one header byte each, payload parity one sample each
	assign tx_par_word = (tx_st_r == asp_pkg::st_hdr)
		? {24'h000000, hdr_byte(cnt_r[1:0], hdr_cc_r)} : txf_out_data;

	asp_parity u_tx_par (
		.word(tx_par_word),
		.par(tx_par)
	);

	always_comb begin
		tx_byte = 8'h00;
		case (tx_st_r)
			asp_pkg::st_hdr: begin
				tx_byte = cnt_r[2] ? tx_par : hdr_byte(cnt_r[1:0], hdr_cc_r);
			end
			asp_pkg::st_pay: begin
				if (cnt_r == asp_pkg::PAR_IDX) begin
					tx_byte = tx_par;
				end else begin
					tx_byte = txf_out_data[8*cnt_r[1:0] +: 8];
				end
			end
			default: tx_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_st_r <= asp_pkg::st_idle;
			cnt_r <= asp_pkg::RST_CNT;
			smp_r <= asp_pkg::RST_CNT;
			hdr_cc_r <= 4'h0;
		end else begin
			case (tx_st_r)
				asp_pkg::st_idle: begin
					if (txf_count >= CW'(asp_pkg::SMP_PER_PKT) && chan_ok) begin
						tx_st_r <= asp_pkg::st_hdr;
						cnt_r <= asp_pkg::RST_CNT;
						hdr_cc_r <= cfg_chan_count - 4'h1;
					end
				end
				asp_pkg::st_hdr: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == asp_pkg::HDR_LAST) begin
						tx_st_r <= asp_pkg::st_pay;
						cnt_r <= asp_pkg::RST_CNT;
						smp_r <= asp_pkg::RST_CNT;
					end
				end
				asp_pkg::st_pay: begin
					if (cnt_r == asp_pkg::PAR_IDX) begin
						cnt_r <= asp_pkg::RST_CNT;
						smp_r <= smp_r + 3'h1;
						if (smp_r == asp_pkg::SMP_LAST) begin
							tx_st_r <= asp_pkg::st_idle;
						end
					end else begin
						cnt_r <= cnt_r + 3'h1;
					end
				end
				default: tx_st_r <= asp_pkg::st_idle;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_data_r <= 8'h00;
			tx_valid_r <= asp_pkg::RST_FLAG;
			tx_sop_r <= asp_pkg::RST_FLAG;
			tx_eop_r <= asp_pkg::RST_FLAG;
		end else begin
			tx_data_r <= tx_byte;
			tx_valid_r <= tx_st_r != asp_pkg::st_idle;
			tx_sop_r <= tx_st_r == asp_pkg::st_hdr && cnt_r == asp_pkg::RST_CNT;
			tx_eop_r <= txf_out_ready && smp_r == asp_pkg::SMP_LAST;
		end
	end

	assign tx_pkt_data = tx_data_r;
	assign tx_pkt_valid = tx_valid_r;
	assign tx_pkt_sop = tx_sop_r;
	assign tx_pkt_eop = tx_eop_r;
	assign cfg_unsupported = unsup_r;

	// receive path
	asp_pkg::asp_state_t rx_st_r;
	logic [2:0] rcnt_r;
	logic [2:0] rsmp_r;
	logic hdr_bad_r;
	logic [7:0] hdr_r [asp_pkg::HDR_BYTES];
	logic [31:0] w_r;
	logic [31:0] rx_par_word;
	logic [7:0] rx_par;
	logic rx_par_match;
	logic rx_byte;
	logic hdr_end;
	logic hdr_good;
	logic par_slot;
	logic rx_push;
	logic rxf_in_ready;
	logic rxf_out_valid;
	logic [31:0] rxf_out_data;
	logic [31:0] m_data_r;
	logic m_valid_r;
	logic ovf_r;
	logic perr_r;
	logic drop_r;

	assign rx_par_word = (rx_st_r == asp_pkg::st_hdr)
		? {24'h000000, hdr_r[rcnt_r[1:0]]} : w_r;

	asp_parity u_rx_par (
		.word(rx_par_word),
		.par(rx_par)
	);

	assign rx_byte = rx_pkt_valid && !rx_pkt_sop;
	assign rx_par_match = rx_par == rx_pkt_data;
	assign hdr_end = rx_byte && rx_st_r == asp_pkg::st_hdr && rcnt_r == asp_pkg::HDR_LAST;
	assign hdr_good = !hdr_bad_r && rx_par_match && hdr_r[0] == asp_pkg::HB0_ID
		&& hdr_r[1] == asp_pkg::HB1_TYPE_AUDIO;
	assign par_slot = rx_byte && ((rx_st_r == asp_pkg::st_hdr && rcnt_r[2])
		|| (rx_st_r == asp_pkg::st_pay && rcnt_r == asp_pkg::PAR_IDX));
	assign rx_push = par_slot && rx_st_r == asp_pkg::st_pay && rx_par_match;

	always_ff @(posedge clk) begin
		if (rx_pkt_valid && rx_pkt_sop) begin
			hdr_r[0] <= rx_pkt_data;
		end else if (rx_byte && rx_st_r == asp_pkg::st_hdr && !rcnt_r[2]) begin
			hdr_r[rcnt_r[1:0]] <= rx_pkt_data;
		end
		if (rx_byte && rx_st_r == asp_pkg::st_pay && rcnt_r != asp_pkg::PAR_IDX) begin
			w_r[8*rcnt_r[1:0] +: 8] <= rx_pkt_data;
		end
	end

	// a start byte always restarts the parser, even inside a packet
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_st_r <= asp_pkg::st_idle;
			rcnt_r <= asp_pkg::RST_CNT;
			rsmp_r <= asp_pkg::RST_CNT;
			hdr_bad_r <= asp_pkg::RST_FLAG;
		end else if (rx_pkt_valid && rx_pkt_sop) begin
			rx_st_r <= asp_pkg::st_hdr;
			rcnt_r <= 3'h1;
			hdr_bad_r <= asp_pkg::RST_FLAG;
		end else if (rx_byte) begin
			case (rx_st_r)
				asp_pkg::st_hdr: begin
					rcnt_r <= rcnt_r + 3'h1;
					if (par_slot && !rx_par_match) begin
						hdr_bad_r <= 1'b1;
					end
					if (hdr_end) begin
						rcnt_r <= asp_pkg::RST_CNT;
						rsmp_r <= asp_pkg::RST_CNT;
						rx_st_r <= hdr_good ? asp_pkg::st_pay : asp_pkg::st_idle;
					end
				end
				asp_pkg::st_pay: begin
					if (rcnt_r == asp_pkg::PAR_IDX) begin
						rcnt_r <= asp_pkg::RST_CNT;
						rsmp_r <= rsmp_r + 3'h1;
						if (rsmp_r == asp_pkg::SMP_LAST) begin
							rx_st_r <= asp_pkg::st_idle;
						end
					end else begin
						rcnt_r <= rcnt_r + 3'h1;
					end
				end
				default: rx_st_r <= asp_pkg::st_idle;
			endcase
		end
	end

	asp_fifo #(
		.WIDTH(asp_pkg::DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_rxf (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(rx_push),
		.in_ready(rxf_in_ready),
		.in_data(w_r),
		.out_valid(rxf_out_valid),
		.out_ready(rxf_out_valid),
		.out_data(rxf_out_data),
		.count()
	);

	// sink takes every word, so the buffer drains one word per cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			m_data_r <= 32'h00000000;
			m_valid_r <= asp_pkg::RST_FLAG;
		end else begin
			m_valid_r <= rxf_out_valid;
			if (rxf_out_valid) begin
				m_data_r <= rxf_out_data;
			end
		end
	end

	// sticky flags: a new event beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ovf_r <= asp_pkg::RST_FLAG;
			perr_r <= asp_pkg::RST_FLAG;
			drop_r <= asp_pkg::RST_FLAG;
		end else begin
			ovf_r <= (rx_push && !rxf_in_ready) || (ovf_r && !rx_flag_clear);
			perr_r <= (par_slot && !rx_par_match) || (perr_r && !rx_flag_clear);
			drop_r <= (hdr_end && !hdr_good) || (drop_r && !rx_flag_clear);
		end
	end

	assign m_axis_tdata = m_data_r;
	assign m_axis_tvalid = m_valid_r;
	assign rx_overflow = ovf_r;
	assign rx_parity_err = perr_r;
	assign rx_pkt_dropped = drop_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_tx_start;
		tx_pkt_sop;
	endsequence
	sequence s_tx_end;
		tx_pkt_eop ##1 !tx_pkt_valid;
	endsequence

	a_fifo_grows_handshake: assert property (
		txf_count > $past(txf_count) |-> $past(s_axis_tvalid && s_axis_tready))
		else $error("ingress buffer grew without a handshake");
	a_ready_needs_space: assert property (
		s_axis_tready |-> txf_in_ready && $past(accept_ok))
		else $error("ready while full or disabled");
	a_packet_length: assert property (
		s_tx_start |-> ##47 s_tx_end)
		else $error("packet is not 48 bytes");
	a_eight_before_send: assert property (
		tx_st_r == asp_pkg::st_idle ##1 tx_st_r == asp_pkg::st_hdr
		|-> $past(txf_count) >= CW'(asp_pkg::SMP_PER_PKT))
		else $error("packet started with fewer than eight samples");
	a_multichan_blocked: assert property (
		!chan_ok |=> !s_axis_tready ##0 cfg_unsupported)
		else $error("unsupported channel count accepted");
	a_hold_until_packed: assert property (
		txf_out_ready |=> tx_pkt_data == $past(tx_par) ##0 tx_st_r != asp_pkg::st_hdr)
		else $error("sample left the buffer outside payload");
	a_rx_no_stall: assert property (
		rxf_out_valid |=> m_axis_tvalid && m_axis_tdata == $past(rxf_out_data))
		else $error("buffered word not delivered next cycle");
	a_overflow_sticky: assert property (
		rx_push && !rxf_in_ready |=> rx_overflow ##1 (rx_overflow || $past(rx_flag_clear)))
		else $error("overflow not flagged");
	a_type_filter: assert property (
		hdr_end && hdr_r[1] != asp_pkg::HB1_TYPE_AUDIO |=> rx_st_r == asp_pkg::st_idle && rx_pkt_dropped)
		else $error("foreign packet type not dropped");
endmodule : asp_packetizer

// >>> verilog/asp_parity.sv
module asp_parity (
	input wire logic [31:0] word,
	output logic [7:0] par
);
	// each byte rotated by its lane before folding, so swapped bytes are caught
	assign par = asp_pkg::PAR_SEED ^ word[7:0] ^ {word[14:8], word[15]}
		^ {word[21:16], word[23:22]} ^ {word[28:24], word[31:29]};
endmodule : asp_parity

// >>> verilog/asp_pkg.sv
package asp_pkg;
	// stream word layout, high to low: control, sample, preamble
	localparam int DATA_W = 32;
	localparam int PRE_LSB = 0;
	localparam int PRE_W = 4;
	localparam int SMP_LSB = 4;
	localparam int SMP_W = 24;
	localparam int CTL_LSB = 28;
	localparam int CTL_W = 4;
	// packet geometry
	localparam int HDR_BYTES = 4;
	localparam int HDR_PAR_BYTES = 4;
	localparam int SMP_BYTES = 32;
	localparam int PAY_PAR_BYTES = 8;
	localparam int SMP_PER_PKT = 8;
	localparam int BYTES_PER_SMP = SMP_BYTES / SMP_PER_PKT;
	localparam int PKT_BYTES = HDR_BYTES + HDR_PAR_BYTES + SMP_BYTES + PAY_PAR_BYTES;
	localparam logic [2:0] HDR_LAST = 3'(HDR_BYTES + HDR_PAR_BYTES - 1);
	localparam logic [2:0] PAR_IDX = 3'(BYTES_PER_SMP);
	localparam logic [2:0] SMP_LAST = 3'(SMP_PER_PKT - 1);
	localparam int FIFO_DEPTH = 16;
	// header bytes of the audio stream packet
	localparam logic [7:0] HB0_ID = 8'h00;
	localparam logic [7:0] HB1_TYPE_AUDIO = 8'h02;
	localparam logic [7:0] HB2_RSVD = 8'h00;
	localparam logic [3:0] MIN_CHAN = 4'h1;
	localparam logic [3:0] MAX_CHAN = 4'h2;
	localparam logic [7:0] PAR_SEED = 8'hA5;
	// values after reset
	localparam logic RST_FLAG = 1'b0;
	localparam logic [2:0] RST_CNT = 3'h0;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_hdr = 2'b01,
		st_pay = 2'b11
	} asp_state_t;
endpackage : asp_pkg
